//--- verilog/dtp_defs.svh
// Register offsets, field positions, reset values and timing counts of the dual timer PWM unit
`ifndef DTP_DEFS_SVH
`define DTP_DEFS_SVH
// ==========================================
// Register offsets (byte addresses)
`define DTP_OFS_T1 8'h10
`define DTP_OFS_T2 8'h11
`define DTP_OFS_T3_LO 8'h12
`define DTP_OFS_T3_HI 8'h13
`define DTP_OFS_PER1 8'h14
`define DTP_OFS_PER2 8'h15
`define DTP_OFS_CFG 8'h16
`define DTP_OFS_PER3_LO 8'h17
`define DTP_OFS_PER3_HI 8'h18
`define DTP_OFS_PWMA_LO 8'h19
`define DTP_OFS_RUN 8'h1f
`define DTP_OFS_STAT 8'h20
`define DTP_OFS_MASK 8'h21
// ==========================================
// Field positions
`define DTP_CFG_SRC1 0
`define DTP_CFG_SRC2 1
`define DTP_CFG_SRC3 2
`define DTP_CFG_CASC 3
`define DTP_RUN_T1 0
`define DTP_RUN_T2 1
`define DTP_RUN_T3 2
`define DTP_RUN_PWM0 3
`define DTP_LO_TBSEL 5
// ==========================================
// Reset values
`define DTP_RST_CFG 8'h00
`define DTP_RST_RUN 8'h00
`define DTP_RST_PER 8'hff
`define DTP_RST_PER3 16'hffff
// ==========================================
// Timing: the clock is the oscillator, one instruction cycle is four of them
`define DTP_TOSC_NS 20
`define DTP_CLK_NS 20
`define DTP_QUARTERS 4
`define DTP_ICYC_CLKS ((`DTP_QUARTERS * `DTP_TOSC_NS) / `DTP_CLK_NS)
`endif

//--- verilog/dtp_pkg.sv
// Types shared by the dual timer PWM unit
`default_nettype none
package dtp_pkg;
  // 10-bit duty value: high byte above the two low bits
  typedef struct packed {
    logic [7:0] high;
    logic [1:0] low;
  } dtp_duty_s;
  // Internal instruction clock or external pin edge
  typedef enum logic [1:0] {
    DTP_SRC_INT = 2'b01,
    DTP_SRC_EXT = 2'b10
  } dtp_src_e;
endpackage : dtp_pkg
`default_nettype wire

//--- verilog/dtp_unit.sv
// Dual 8-bit timers, 16-bit wide timer and three double-buffered PWM outputs
// Functional notes
// - two 8-bit timers, own period, own flag
// - timers count instruction clock or pin falls
// - cascade bit joins both into 16 bits
// - wide 16-bit timer with period register pair
// - first PWM always on first timer
// - other PWMs pick timer by select bit
// - PWM period is (period+1) instruction cycles
// - duty is high byte plus bits 7:6
// - high time is duty oscillator periods
// - zero duty keeps output low
// - duty above period gives full high
// - rollover copies master duty into slave
// - duty reads return the slave latch
// - match then clear to zero, raise event
// - flags sticky, only software clears them
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.svh"
module dtp_unit (
  input wire logic clk_in, // Oscillator clock, 50 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic ce_in, // Clock enable, freezes all state when low
  input wire logic [7:0] addr_in, // Register address
  input wire logic [7:0] wdata_in, // Register write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [7:0] rdata_out, // Read data, valid the cycle after rd_in
  input wire logic small_timer_ext_clock_pin_in, // External clock for the 8-bit timers
  input wire logic wide_timer_ext_clock_pin_in, // External clock for the wide timer
  output logic [2:0] pwm_out, // PWM outputs a, b, c
  output logic irq_out // Level interrupt
);
  // ==========================================
  // Storage
  logic [7:0] first_small_timer; // Timer one count
  logic [7:0] second_small_timer; // Timer two count
  logic [15:0] wide_capture_timer; // Wide timer count
  logic [7:0] first_period_value; // Timer one period
  logic [7:0] second_period_value; // Timer two period
  logic [15:0] wide_period_capture; // Wide timer period pair
  logic [7:0] timer_clock_capture_config; // Sources and cascade
  logic [7:0] run_control; // Timer run and PWM enable bits
  logic [2:0] int_status; // Sticky period flags
  logic [2:0] int_mask; // Interrupt enables
  logic [1:0] quarter; // Position within the instruction cycle
  logic small_pin_prev; // Last sample of the small timer pin
  logic wide_pin_prev; // Last sample of the wide timer pin
  dtp_pkg::dtp_duty_s duty_master [3]; // Written by software
  dtp_pkg::dtp_duty_s duty_slave [3]; // Steers the outputs
  logic tb_sel [3]; // Timer two select per channel
  logic [7:0] next_rdata; // Read mux
  // ==========================================
  // Decode
  // Byte writes to the timers are decoded here so counting can give way to them
  logic wr_t1, wr_t2, wr_t3l, wr_t3h;
  logic icyc, small_fall, wide_fall, cascade;
  logic tick1, tick2, tick3, inc1, inc2, inc3;
  logic match1, match2, match16, roll1, roll2, roll3;
  dtp_pkg::dtp_src_e src1, src2, src3;
  assign wr_t1 = wr_in && addr_in == `DTP_OFS_T1;
  assign wr_t2 = wr_in && addr_in == `DTP_OFS_T2;
  assign wr_t3l = wr_in && addr_in == `DTP_OFS_T3_LO;
  assign wr_t3h = wr_in && addr_in == `DTP_OFS_T3_HI;
  assign cascade = timer_clock_capture_config[`DTP_CFG_CASC];
  // ==========================================
  // Instruction clock and pin edges
  // Quarter counter divides the oscillator by four
  // Limitation: the phase keeps running in pin mode, so duty fractions there are not aligned
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      quarter <= 2'h0;
    end else if (ce_in) begin
      quarter <= quarter + 2'h1;
    end
  end
  // Pins are synchronous, so one sample is enough to spot a falling edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      small_pin_prev <= 1'b0;
      wide_pin_prev <= 1'b0;
    end else if (ce_in) begin
      small_pin_prev <= small_timer_ext_clock_pin_in;
      wide_pin_prev <= wide_timer_ext_clock_pin_in;
    end
  end
  assign icyc = quarter == 2'(`DTP_ICYC_CLKS - 1);
  assign small_fall = small_pin_prev && !small_timer_ext_clock_pin_in;
  assign wide_fall = wide_pin_prev && !wide_timer_ext_clock_pin_in;
  assign src1 = timer_clock_capture_config[`DTP_CFG_SRC1] ? dtp_pkg::DTP_SRC_EXT : dtp_pkg::DTP_SRC_INT;
  assign src2 = timer_clock_capture_config[`DTP_CFG_SRC2] ? dtp_pkg::DTP_SRC_EXT : dtp_pkg::DTP_SRC_INT;
  assign src3 = timer_clock_capture_config[`DTP_CFG_SRC3] ? dtp_pkg::DTP_SRC_EXT : dtp_pkg::DTP_SRC_INT;
  assign tick1 = (src1 == dtp_pkg::DTP_SRC_EXT) ? small_fall : icyc;
  assign tick2 = (src2 == dtp_pkg::DTP_SRC_EXT) ? small_fall : icyc;
  assign tick3 = (src3 == dtp_pkg::DTP_SRC_EXT) ? wide_fall : icyc;
  assign inc1 = ce_in && run_control[`DTP_RUN_T1] && tick1;
  // Timer two follows its own clock only when not cascaded
  assign inc2 = ce_in && !cascade && run_control[`DTP_RUN_T2] && tick2;
  assign inc3 = ce_in && run_control[`DTP_RUN_T3] && tick3;
  // ==========================================
  // Period matches
  // combined compare
  assign match16 = {second_small_timer, first_small_timer} == {second_period_value, first_period_value};
  assign match1 = cascade ? match16 : first_small_timer == first_period_value;
  assign match2 = second_small_timer == second_period_value;
  assign roll1 = inc1 && match1;
  assign roll2 = inc2 && match2;
  assign roll3 = inc3 && wide_capture_timer == wide_period_capture;
  // ==========================================
  // Timer one; a bus write wins over counting
  // first timer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      first_small_timer <= 8'h00;
    end else if (ce_in) begin
      if (wr_t1) begin
        first_small_timer <= wdata_in;
      end else if (roll1) begin
        first_small_timer <= 8'h00;
      end else if (inc1) begin
        first_small_timer <= first_small_timer + 8'h01;
      end
    end
  end
  // Timer two, either alone or as the upper byte
  // Hazard: software must keep PWMs off while cascaded, or the channel periods break
  // cascade carry
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_small_timer <= 8'h00;
    end else if (ce_in) begin
      if (wr_t2) begin
        second_small_timer <= wdata_in;
      end else if (roll1 && cascade) begin
        second_small_timer <= 8'h00;
      end else if (cascade && inc1 && first_small_timer == 8'hff) begin
        second_small_timer <= second_small_timer + 8'h01;
      end else if (roll2) begin
        second_small_timer <= 8'h00;
      end else if (inc2) begin
        second_small_timer <= second_small_timer + 8'h01;
      end
    end
  end
  // Wide timer wraps at its period pair
  // wide timer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wide_capture_timer <= 16'h0000;
    end else if (ce_in) begin
      if (wr_t3l) begin
        wide_capture_timer[7:0] <= wdata_in;
      end else if (wr_t3h) begin
        wide_capture_timer[15:8] <= wdata_in;
      end else if (roll3) begin
        wide_capture_timer <= 16'h0000;
      end else if (inc3) begin
        wide_capture_timer <= wide_capture_timer + 16'h0001;
      end
    end
  end
  // ==========================================
  // Configuration registers
  // Run bits 7:6 do not exist and read as zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      first_period_value <= `DTP_RST_PER;
      second_period_value <= `DTP_RST_PER;
      wide_period_capture <= `DTP_RST_PER3;
      timer_clock_capture_config <= `DTP_RST_CFG;
      run_control <= `DTP_RST_RUN;
      int_mask <= 3'h0;
    end else if (ce_in && wr_in) begin
      case (addr_in)
        `DTP_OFS_PER1: first_period_value <= wdata_in;
        `DTP_OFS_PER2: second_period_value <= wdata_in;
        `DTP_OFS_PER3_LO: wide_period_capture[7:0] <= wdata_in;
        `DTP_OFS_PER3_HI: wide_period_capture[15:8] <= wdata_in;
        `DTP_OFS_CFG: timer_clock_capture_config <= wdata_in;
        `DTP_OFS_RUN: run_control <= {2'h0, wdata_in[5:0]};
        `DTP_OFS_MASK: int_mask <= wdata_in[2:0];
        default: begin
        end
      endcase
    end
  end
  // ==========================================
  // Interrupt flags: write one to clear, a new event beats the clear
  // sticky flags
  // A clear written in the same cycle as an event loses, so no event is dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_status <= 3'h0;
    end else if (ce_in) begin
      int_status <= (int_status & ~((wr_in && addr_in == `DTP_OFS_STAT) ? wdata_in[2:0] : 3'h0))
        | {roll3, roll2, roll1};
    end
  end
  assign irq_out = |(int_status & int_mask);
  // ==========================================
  // PWM channels
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pwm
      localparam logic [7:0] LO_OFS = 8'(`DTP_OFS_PWMA_LO + 2 * gi);
      logic use_t2; // Channel runs on timer two
      logic roll_sel; // Rollover of the chosen timer
      logic [9:0] fine; // Timer count extended by the quarter phase
      logic pwm_q; // Registered output
      // first channel fixed on timer one
      assign use_t2 = (gi != 0) && tb_sel[gi];
      assign roll_sel = use_t2 ? roll2 : roll1;
      // period from the chosen timer and period register
      assign fine = use_t2 ? {second_small_timer, quarter} : {first_small_timer, quarter};
      // Master latches take software writes
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          duty_master[gi] <= '0;
          tb_sel[gi] <= 1'b0;
        end else if (ce_in && wr_in) begin
          if (addr_in == LO_OFS) begin
            duty_master[gi].low <= wdata_in[7:6];
            tb_sel[gi] <= (gi != 0) && wdata_in[`DTP_LO_TBSEL];
          end else if (addr_in == 8'(LO_OFS + 8'h01)) begin
            duty_master[gi].high <= wdata_in;
          end
        end
      end
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          duty_slave[gi] <= '0;
        end else if (ce_in && roll_sel) begin
          duty_slave[gi] <= duty_master[gi];
        end
      end
      // Output is high while the fine count is below the duty; the
      // register adds one clock of delay on both edges
      // Trade-off: that one clock of lag keeps the pin free of glitches
      // quarter resolution compare
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          pwm_q <= 1'b0;
        end else if (ce_in) begin
          pwm_q <= run_control[`DTP_RUN_PWM0 + gi] && (fine < duty_slave[gi]);
        end
      end
      assign pwm_out[gi] = pwm_q;
    end
  endgenerate
  // ==========================================
  // Register read
  // duty reads show slaves
  // duty split across two registers
  // Unmapped addresses read as zero; the timebase bits read live, not buffered
  always_comb begin
    next_rdata = 8'h00;
    case (addr_in)
      `DTP_OFS_T1: next_rdata = first_small_timer;
      `DTP_OFS_T2: next_rdata = second_small_timer;
      `DTP_OFS_T3_LO: next_rdata = wide_capture_timer[7:0];
      `DTP_OFS_T3_HI: next_rdata = wide_capture_timer[15:8];
      `DTP_OFS_PER1: next_rdata = first_period_value;
      `DTP_OFS_PER2: next_rdata = second_period_value;
      `DTP_OFS_CFG: next_rdata = timer_clock_capture_config;
      `DTP_OFS_PER3_LO: next_rdata = wide_period_capture[7:0];
      `DTP_OFS_PER3_HI: next_rdata = wide_period_capture[15:8];
      8'h19: next_rdata = {duty_slave[0].low, 6'h00};
      8'h1a: next_rdata = duty_slave[0].high;
      8'h1b: next_rdata = {duty_slave[1].low, tb_sel[1], 5'h00};
      8'h1c: next_rdata = duty_slave[1].high;
      8'h1d: next_rdata = {duty_slave[2].low, tb_sel[2], 5'h00};
      8'h1e: next_rdata = duty_slave[2].high;
      `DTP_OFS_RUN: next_rdata = run_control;
      `DTP_OFS_STAT: next_rdata = {5'h00, int_status};
      `DTP_OFS_MASK: next_rdata = {5'h00, int_mask};
      default: next_rdata = 8'h00;
    endcase
  end
  // Data stands only in the cycle after the strobe
  // Zero outside the answer cycle lets a bus merge several slaves by OR
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= rd_in ? next_rdata : 8'h00;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_flag_sticky: assert property (int_status[0] && !(wr_in && addr_in == `DTP_OFS_STAT && wdata_in[0])
    |=> int_status[0]) else $error("timer one flag lost");
  a_event_sets: assert property (roll2 |=> int_status[1]) else $error("timer two event not latched");
  a_roll_zero: assert property (roll1 && !wr_t1 |=> first_small_timer == 8'h00)
    else $error("timer one did not clear at match");
  a_t1_count: assert property (inc1 && !match1 && !wr_t1 && src1 == dtp_pkg::DTP_SRC_INT
    |=> first_small_timer == 8'($past(first_small_timer) + 8'h01)) else $error("timer one missed a tick");
  a_cascade_carry: assert property (cascade && inc1 && !match1 && first_small_timer == 8'hff && !wr_t2
    |=> second_small_timer == 8'($past(second_small_timer) + 8'h01)) else $error("cascade carry lost");
  a_wide_wrap: assert property (roll3 && !wr_t3l && !wr_t3h |=> wide_capture_timer == 16'h0000)
    else $error("wide timer did not wrap");
  a_duty_copy: assert property (ce_in && roll1 |=> duty_slave[0] == $past(duty_master[0]))
    else $error("duty not transferred");
  a_zero_low: assert property (ce_in && duty_slave[0] == 10'h000 |=> !pwm_out[0])
    else $error("zero duty drove high");
  a_full_high: assert property (ce_in && run_control[`DTP_RUN_PWM0] && duty_slave[0].high > first_period_value
    |=> pwm_out[0]) else $error("duty above period not full high");
  a_b_base: assert property (ce_in && tb_sel[1] && roll2 |=> duty_slave[1] == $past(duty_master[1]))
    else $error("channel b ignored timer two");
  a_read_slave: assert property (ce_in && rd_in && addr_in == 8'h1a |=> rdata_out == $past(duty_slave[0].high))
    else $error("duty read not from slave");
  // ==========================================
  // Period start, cascade, wide timer and disabled channel b checks
  // timer two quiet
  a_t2_quiet: assert property (cascade && !wr_t2 && !roll1 && !(inc1 && first_small_timer == 8'hff)
    |=> second_small_timer == $past(second_small_timer)) else $error("timer two moved on its own clock");
  // period start high, one clock of output lag
  a_period_high: assert property (ce_in && roll1 && !wr_in && run_control[`DTP_RUN_PWM0]
    && src1 == dtp_pkg::DTP_SRC_INT && duty_master[0] != 10'h000 ##1 ce_in |=> pwm_out[0])
    else $error("new period did not start high");
  a_wide_count: assert property (inc3 && !roll3 && !wr_t3l && !wr_t3h
    |=> wide_capture_timer == 16'($past(wide_capture_timer) + 16'h0001)) else $error("wide timer missed a tick");
  a_b_disabled: assert property (ce_in && !run_control[`DTP_RUN_PWM0 + 1] |=> !pwm_out[1])
    else $error("disabled channel b drove high");
  c_cascade_carry: cover property (cascade && inc1 && first_small_timer == 8'hff);
  c_roll1: cover property (roll1);
  c_cascade_roll: cover property (cascade && roll1);
  c_irq: cover property (!irq_out ##1 irq_out);
  c_pwm_pulse: cover property (pwm_out[1] ##1 !pwm_out[1]);
endmodule : dtp_unit
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking testbench of the dual timer PWM unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================
  // Stimulus and observed signals
  logic clk_in = 1'b0; // Oscillator clock, 20 ns
  logic rst_in = 1'b1; // Synchronous reset
  logic [7:0] addr = 8'h00; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic pin = 1'b1; // Small timer pin, idles high
  logic wpin = 1'b1; // Wide timer pin, idles high
  logic [7:0] rdata; // Read data
  logic [2:0] pwm; // PWM levels
  logic irq; // Interrupt level
  logic [7:0] got; // Last read value
  int failures = 0; // Mismatches
  int compares = 0; // Comparisons made
  int cycles = 0; // Timeout counter
  int hi_cnt; // High cycles in a window
  int pc; // PWM period in clocks
  int d; // Duty in clocks
  // Register rows: address, write or not, data, expected read
  typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_s;
  row_s regs[16] = '{'{8'h16, 0, 8'h00, 8'h00}, '{8'h14, 0, 8'h00, 8'hff}, '{8'h15, 0, 8'h00, 8'hff},
    '{8'h17, 0, 8'h00, 8'hff}, '{8'h18, 0, 8'h00, 8'hff}, '{8'h1f, 0, 8'h00, 8'h00}, '{8'h20, 0, 8'h00, 8'h00},
    '{8'h21, 0, 8'h00, 8'h00}, '{8'h10, 0, 8'h00, 8'h00}, '{8'h16, 1, 8'ha5, 8'ha5}, '{8'h17, 1, 8'h12, 8'h12},
    '{8'h18, 1, 8'h34, 8'h34}, '{8'h21, 1, 8'h03, 8'h03}, '{8'h30, 1, 8'h5a, 8'h00}, '{8'h16, 1, 8'h00, 8'h00},
    '{8'h15, 1, 8'h01, 8'h01}};
  // PWM rows: channel, timebase select, duty high byte, duty low bits
  typedef struct {int ch; logic tb; logic [7:0] dh; logic [1:0] lb;} pw_s;
  pw_s pws[8] = '{'{0, 0, 8'h00, 2'h0}, '{0, 0, 8'h01, 2'h1}, '{0, 0, 8'h03, 2'h2}, '{1, 1, 8'h01, 2'h3},
    '{1, 0, 8'h02, 2'h0}, '{2, 1, 8'h00, 2'h2}, '{2, 0, 8'h03, 2'h3}, '{0, 0, 8'h04, 2'h0}};

  dtp_unit dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .small_timer_ext_clock_pin_in(pin),
    .wide_timer_ext_clock_pin_in(wpin), .pwm_out(pwm), .irq_out(irq));

  // ==========================================
  // Clock and hang guard
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // Ceiling is well above the roughly 2000 clocks the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  // Write strobe is one cycle; the next call waits an edge before raising it again
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    got = rdata;
    check(got & m, e);
  endtask : rd_chk
  // Count high cycles of one PWM output over n clocks
  task automatic count_hi(input int ch, input int n);
    hi_cnt = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (pwm[ch] === 1'b1) hi_cnt++;
    end
  endtask : count_hi
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // Main sequence
  initial begin
    idle(4);
    rst_in <= 1'b0;
    foreach (regs[i]) begin
      if (regs[i].w) reg_wr(regs[i].a, regs[i].d);
      rd_chk(regs[i].a, 8'hff, regs[i].e);
    end
    $display("test register rows done");
    // Period one is 3, period two is 1; run all timers and PWMs
    reg_wr(8'h14, 8'h03);
    reg_wr(8'h1f, 8'h3f);
    foreach (pws[i]) begin
      pc = 4 * (((pws[i].ch == 0) || !pws[i].tb) ? 4 : 2);
      d = 4 * pws[i].dh + pws[i].lb;
      reg_wr(8'h19 + 8'(2 * pws[i].ch), {pws[i].lb, pws[i].tb, 5'h00});
      reg_wr(8'h1a + 8'(2 * pws[i].ch), pws[i].dh);
      idle(2 * pc + 8);
      count_hi(pws[i].ch, 2 * pc);
      check(16'(hi_cnt), 16'(2 * (d >= pc ? pc : d)));
    end
    $display("test pwm rows done");
    // Stopped timers never roll over, so reads keep the old slave value
    // duty bytes are written whole, never read-modified
    reg_wr(8'h1f, 8'h00);
    reg_wr(8'h19, 8'h40);
    reg_wr(8'h1a, 8'h01);
    rd_chk(8'h1a, 8'hff, 8'h04);
    reg_wr(8'h1f, 8'h09);
    idle(20);
    rd_chk(8'h1a, 8'hff, 8'h01);
    rd_chk(8'h19, 8'hff, 8'h40);
    count_hi(0, 32);
    check(16'(hi_cnt), 16'h000a);
    $display("test double buffer done");
    // Flags latch, mask gates the level, only a written one clears
    reg_wr(8'h21, 8'h00);
    reg_wr(8'h1f, 8'h03);
    idle(40);
    rd_chk(8'h20, 8'h03, 8'h03);
    check(16'(irq), 16'h0000);
    reg_wr(8'h21, 8'h02);
    idle(1);
    check(16'(irq), 16'h0001);
    reg_wr(8'h1f, 8'h00);
    reg_wr(8'h20, 8'h02);
    idle(50);
    rd_chk(8'h20, 8'h07, 8'h01);
    check(16'(irq), 16'h0000);
    reg_wr(8'h20, 8'h07);
    rd_chk(8'h20, 8'h07, 8'h00);
    $display("test interrupt done");
    // Cascade: carry from timer one, combined period 0x0102
    // every PWM stays off while cascaded
    reg_wr(8'h16, 8'h08);
    reg_wr(8'h14, 8'h02);
    reg_wr(8'h15, 8'h01);
    reg_wr(8'h10, 8'hfe);
    reg_wr(8'h11, 8'h00);
    reg_wr(8'h1f, 8'h03);
    idle(10);
    reg_wr(8'h1f, 8'h00);
    rd_chk(8'h11, 8'hff, 8'h01);
    reg_wr(8'h10, 8'h00);
    reg_wr(8'h11, 8'h00);
    reg_wr(8'h20, 8'h07);
    reg_wr(8'h1f, 8'h03);
    idle(40);
    rd_chk(8'h20, 8'h07, 8'h00);
    idle(1020);
    rd_chk(8'h20, 8'h07, 8'h01);
    $display("test cascade done");
    // Pin clock: five falling edges give five counts
    reg_wr(8'h1f, 8'h00);
    reg_wr(8'h16, 8'h05);
    reg_wr(8'h14, 8'hff);
    reg_wr(8'h10, 8'h00);
    reg_wr(8'h12, 8'h00);
    reg_wr(8'h13, 8'h00);
    reg_wr(8'h1f, 8'h05);
    repeat (5) begin
      @(posedge clk_in);
      pin <= 1'b0;
      wpin <= 1'b0;
      idle(2);
      pin <= 1'b1;
      wpin <= 1'b1;
      idle(2);
    end
    idle(3);
    rd_chk(8'h10, 8'hff, 8'h05);
    rd_chk(8'h12, 8'hff, 8'h05);
    $display("test pin clock done");
    // Second reset in mid-run
    rst_in <= 1'b1;
    idle(2);
    rst_in <= 1'b0;
    check(16'(pwm), 16'h0000);
    rd_chk(8'h16, 8'hff, 8'h00);
    rd_chk(8'h14, 8'hff, 8'hff);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
